/* File: design/region_memory_protection_unit_regs.vh */
// register addresses, field positions and reset values of the protection unit
`ifndef REGION_MEMORY_PROTECTION_UNIT_REGS_VH
`define REGION_MEMORY_PROTECTION_UNIT_REGS_VH

// byte address of the region select word; the rest are offsets from it
`define REGION_SELECT_ADDR   32'hE000ED98
`define OFF_REGION_SELECT    6'h00
`define OFF_BASE             6'h04
`define OFF_ATTR             6'h08
`define OFF_BASE_ALIAS1      6'h0C
`define OFF_ATTR_ALIAS1      6'h10
`define OFF_BASE_ALIAS2      6'h14
`define OFF_ATTR_ALIAS2      6'h18
`define OFF_BASE_ALIAS3      6'h1C
`define OFF_ATTR_ALIAS3      6'h20
`define OFF_WINDOW_END       32'h00000024

// bus access size codes
`define SIZE_BYTE            2'h0
`define SIZE_HALF            2'h1
`define SIZE_WORD            2'h2

// base address word fields
`define BASE_REGION_LSB      0
`define BASE_REGION_MSB      2
`define BASE_VALID_BIT       4
`define BASE_ADDR_LSB        5

// attribute and size word fields
`define ATTR_ENABLE_BIT      0
`define ATTR_SIZE_LSB        1
`define ATTR_SIZE_MSB        5
`define ATTR_SRD_LSB         8
`define ATTR_SRD_MSB         15
`define ATTR_B_BIT           16
`define ATTR_C_BIT           17
`define ATTR_S_BIT           18
`define ATTR_TEX_LSB         19
`define ATTR_TEX_MSB         21
`define ATTR_AP_LSB          24
`define ATTR_AP_MSB          26
`define ATTR_XN_BIT          28
`define ATTR_WRITABLE        32'h173FFF3F

// size field: a region spans 2^(size+1) bytes
`define SIZE_MIN             5'h04
`define SIZE_SUBREGION_MIN   5'h07

// reset values
`define RESET_REGION_SELECT  3'h0
`define RESET_BASE           27'h0000000
`define RESET_ATTR           32'h00000000

`endif

/* File: design/region_match.v */
// address match of one protection region, with subregion disable
`timescale 1ns/1ps
`include "region_memory_protection_unit_regs.vh"

module region_match (
    // access address
    input  wire [31:0] addr_i,
    // region settings
    input  wire [26:0] base_i,
    input  wire [31:0] attr_i,
    // match result
    output wire        hit_o
);

    wire [4:0]  size_field;
    wire [4:0]  size_eff;
    wire [5:0]  span_log2;
    wire [31:0] base_full;
    wire [31:0] span_mask;
    wire [31:0] sub_shift;
    wire [2:0]  sub_idx;
    wire [7:0]  subregion_disable;
    wire        in_region;
    wire        sub_off;

    // sizes below the smallest legal one are treated as 32 bytes
    assign size_field = attr_i[`ATTR_SIZE_MSB:`ATTR_SIZE_LSB];
    assign size_eff   = (size_field < `SIZE_MIN) ? `SIZE_MIN : size_field;
    assign span_log2  = {1'b0, size_eff} + 6'h01;
    assign base_full  = {base_i, 5'h00};
    assign span_mask  = 32'hFFFFFFFF << span_log2;
    assign in_region  = ((addr_i ^ base_full) & span_mask) == 32'h00000000;

    // eighth of the span that the address lies in, bit 0 lowest
    assign sub_shift  = addr_i >> (span_log2 - 6'h03);
    assign sub_idx    = sub_shift[2:0];
    assign subregion_disable        = attr_i[`ATTR_SRD_MSB:`ATTR_SRD_LSB];
    // small regions ignore the field; software keeps it zero there
    assign sub_off    = (size_eff >= `SIZE_SUBREGION_MIN) && subregion_disable[sub_idx];

    assign hit_o = attr_i[`ATTR_ENABLE_BIT] && in_region && !sub_off;

endmodule // region_match

/* File: design/access_check.v */
// priority resolution and permission check for one access stream
`timescale 1ns/1ps
`include "region_memory_protection_unit_regs.vh"

module access_check #(
    parameter NREG     = 8,
    parameter REGION_W = 3
) (
    // access
    input  wire                 addr_valid_i,
    input  wire [31:0]          addr_i,
    input  wire                 priv_i,
    input  wire                 write_i,
    input  wire                 fetch_i,
    // shared region settings
    input  wire [NREG*27-1:0]   bases_i,
    input  wire [NREG*32-1:0]   attrs_i,
    // result
    output reg                  fault_o,
    output reg                  background_o,
    output reg  [REGION_W-1:0]  region_o,
    output reg  [31:0]          attr_o
);

    wire [NREG-1:0] hits;
    integer         k;

    // one matcher per numbered region
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_match
            region_match u_match (
                .addr_i (addr_i),
                .base_i (bases_i[g*27 +: 27]),
                .attr_i (attrs_i[g*32 +: 32]),
                .hit_o  (hits[g])
            );
        end
    endgenerate

    // access permission decode
    function allowed;
        input [2:0] ap;
        input       priv;
        input       wr;
        begin
            case (ap)
                3'h0:    allowed = 1'b0;
                3'h1:    allowed = priv;
                3'h2:    allowed = priv | !wr;
                3'h3:    allowed = 1'b1;
                3'h5:    allowed = priv & !wr;
                3'h6:    allowed = !wr;
                3'h7:    allowed = !wr;
                default: allowed = 1'b0; // reserved code faults
            endcase
        end
    endfunction

    // ascending scan, so the highest numbered hit is left standing
    always @* begin
        background_o = 1'b1;
        region_o     = {REGION_W{1'b0}};
        attr_o       = 32'h00000000;
        for (k = 0; k < NREG; k = k + 1) begin
            if (hits[k]) begin
                background_o = 1'b0;
                region_o     = k[REGION_W-1:0];
                attr_o       = attrs_i[k*32 +: 32];
            end
        end
        if (!addr_valid_i) begin
            fault_o = 1'b0;
        end else if (background_o) begin
            fault_o = !priv_i;
        end else if (fetch_i && attr_o[`ATTR_XN_BIT]) begin
            fault_o = 1'b1;
        end else begin
            fault_o = !allowed(attr_o[`ATTR_AP_MSB:`ATTR_AP_LSB],
                               priv_i, write_i);
        end
    end

endmodule // access_check

/* File: design/region_memory_protection_unit.v */
// region based memory protection unit: register file and access checks
//
// Function
// - eight numbered regions plus background, each with own base, size, attributes.
// - overlapping hits resolve to the highest numbered enabled region.
// - background uses default map, privileged only; unprivileged accesses fault.
// - fetches and data accesses are checked against the same settings.
// - a prohibited access raises a memory management fault.
// - attribute word allows byte, halfword, word; other registers word only.
// - select, base at +4, attribute at +8; separate or burst writes.
// - base write with valid bit set also loads the region select.
// - base and attribute aliases let one burst program four regions.
// - regions of 256 bytes or more split into eight disableable subregions.
// - subregion disable bit 0 is lowest address, top bit highest.
// - disabled subregion falls through to other regions, else to background.
// - strongly ordered regions are flagged so accesses keep program order.
// - register writes take effect in order, one per cycle.
`timescale 1ns/1ps
`include "region_memory_protection_unit_regs.vh"

module region_memory_protection_unit #(
    parameter NREG     = 8,
    parameter REGION_W = 3
) (
    // clock and reset
    input  wire                clk_i,
    input  wire                sys_rst_i,
    // register port on the private peripheral bus
    input  wire                reg_wr_i,
    input  wire                reg_rd_i,
    input  wire [31:0]         reg_addr_i,
    input  wire [1:0]          reg_size_i,
    input  wire [31:0]         reg_wdata_i,
    output reg                 reg_ack_o,
    output reg                 reg_err_o,
    output reg  [31:0]         reg_rdata_o,
    // instruction fetch check
    input  wire                fetch_valid_i,
    input  wire [31:0]         fetch_addr_i,
    input  wire                fetch_priv_i,
    output reg                 fetch_fault_o,
    // data access check
    input  wire                data_valid_i,
    input  wire [31:0]         data_addr_i,
    input  wire                data_priv_i,
    input  wire                data_write_i,
    output reg                 data_fault_o,
    output reg                 data_background_o,
    output reg                 data_strongly_ordered_o,
    output reg  [REGION_W-1:0] data_region_o,
    output reg  [5:0]          data_mem_type_o,
    // combined fault towards the core
    output reg                 mem_fault_o
);

    // region settings, one entry per numbered region
    reg  [26:0]          base_r [0:NREG-1];
    reg  [31:0]          attr_r [0:NREG-1];
    reg  [REGION_W-1:0]  region_select_r;
    reg  [REGION_W-1:0]  region_select_nxt;

    wire [NREG*27-1:0]   bases_flat;
    wire [NREG*32-1:0]   attrs_flat;

    // register decode
    wire [31:0]          reg_off_full;
    wire                 in_window;
    wire [5:0]           reg_off;
    wire [5:0]           word_off;
    wire                 sel_select;
    wire                 sel_base;
    wire                 sel_attr;
    wire                 word_ok;
    wire                 attr_size_ok;
    wire                 access_ok;
    wire                 req;
    wire [REGION_W-1:0]  base_target;
    wire [31:0]          lane_mask;
    wire [31:0]          attr_cur;

    // check results
    wire                 fetch_fault;
    wire                 data_fault;
    wire                 data_bg;
    wire [REGION_W-1:0]  data_region;
    wire [31:0]          data_attr;

    integer              i;

    // byte lanes touched by an access of the given size and position
    function [31:0] lanes;
        input [1:0] size;
        input [1:0] lo;
        begin
            case (size)
                `SIZE_BYTE: lanes = 32'h000000FF << {lo, 3'h0};
                `SIZE_HALF: lanes = lo[1] ? 32'hFFFF0000 : 32'h0000FFFF;
                `SIZE_WORD: lanes = 32'hFFFFFFFF;
                default:    lanes = 32'h00000000;
            endcase
        end
    endfunction

    // true when the word offset is the base word or one of its aliases
    function is_base_off;
        input [5:0] off;
        begin
            is_base_off = (off == `OFF_BASE)        ||
                          (off == `OFF_BASE_ALIAS1) ||
                          (off == `OFF_BASE_ALIAS2) ||
                          (off == `OFF_BASE_ALIAS3);
        end
    endfunction

    // true when the word offset is the attribute word or an alias
    function is_attr_off;
        input [5:0] off;
        begin
            is_attr_off = (off == `OFF_ATTR)        ||
                          (off == `OFF_ATTR_ALIAS1) ||
                          (off == `OFF_ATTR_ALIAS2) ||
                          (off == `OFF_ATTR_ALIAS3);
        end
    endfunction

    // address window decode relative to the region select word
    assign reg_off_full = reg_addr_i - `REGION_SELECT_ADDR;
    assign in_window    = reg_off_full < `OFF_WINDOW_END;
    assign reg_off      = reg_off_full[5:0];
    assign word_off     = {reg_off[5:2], 2'h0};
    assign sel_select   = in_window && (word_off == `OFF_REGION_SELECT);
    assign sel_base     = in_window && is_base_off(word_off);
    assign sel_attr     = in_window && is_attr_off(word_off);
    assign req          = reg_wr_i | reg_rd_i;

    // size and alignment: only the attribute word takes narrow accesses
    assign word_ok      = (reg_size_i == `SIZE_WORD) &&
                          (reg_off[1:0] == 2'h0);
    assign attr_size_ok = word_ok ||
                          (reg_size_i == `SIZE_BYTE) ||
                          ((reg_size_i == `SIZE_HALF) && !reg_off[0]);
    assign access_ok    = sel_attr ? attr_size_ok
                                   : ((sel_select || sel_base) && word_ok);

    // narrow writes merge into the selected region's attribute word
    assign lane_mask    = lanes(reg_size_i, reg_off[1:0]) & `ATTR_WRITABLE;
    assign attr_cur     = attr_r[region_select_r];

    // a base write carrying the valid bit names its own region
    assign base_target  = reg_wdata_i[`BASE_VALID_BIT] ?
                          reg_wdata_i[`BASE_REGION_MSB:`BASE_REGION_LSB] :
                          region_select_r;

    // region select: a base write with the valid bit overrides the select
    always @* begin
        region_select_nxt = region_select_r;
        if (reg_wr_i && access_ok && sel_select) begin
            region_select_nxt =
                reg_wdata_i[`BASE_REGION_MSB:`BASE_REGION_LSB];
        end else if (reg_wr_i && access_ok && sel_base &&
                     reg_wdata_i[`BASE_VALID_BIT]) begin
            region_select_nxt = base_target;
        end
    end

    // register storage; every accepted write lands by the next edge, in issue order
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            region_select_r <= `RESET_REGION_SELECT;
            for (i = 0; i < NREG; i = i + 1) begin
                base_r[i] <= `RESET_BASE;
                attr_r[i] <= `RESET_ATTR;
            end
        end else begin
            region_select_r <= region_select_nxt;
            if (reg_wr_i && access_ok && sel_base) begin
                base_r[base_target] <= reg_wdata_i[31:`BASE_ADDR_LSB];
            end
            if (reg_wr_i && access_ok && sel_attr) begin
                attr_r[region_select_r] <= (attr_cur & ~lane_mask) |
                                           (reg_wdata_i & lane_mask);
            end
        end
    end

    // register answer one cycle after the request; bad accesses error out
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_ack_o   <= 1'b0;
            reg_err_o   <= 1'b0;
            reg_rdata_o <= 32'h00000000;
        end else begin
            reg_ack_o   <= req;
            reg_err_o   <= req && !access_ok;
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i && access_ok) begin
                if (sel_select) begin
                    reg_rdata_o <= {{(32-REGION_W){1'b0}}, region_select_r};
                end else if (sel_base) begin
                    // valid bit always reads back as zero
                    reg_rdata_o <= {base_r[region_select_r], 1'b0,
                                    {(4-REGION_W){1'b0}}, region_select_r};
                end else begin
                    reg_rdata_o <= attr_cur;
                end
            end
        end
    end

    // flatten the shared settings for both checkers
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_flat
            assign bases_flat[g*27 +: 27] = base_r[g];
            assign attrs_flat[g*32 +: 32] = attr_r[g];
        end
    endgenerate

    // instruction stream: same region table as data
    access_check #(
        .NREG     (NREG),
        .REGION_W (REGION_W)
    ) u_fetch_check (
        .addr_valid_i (fetch_valid_i),
        .addr_i       (fetch_addr_i),
        .priv_i       (fetch_priv_i),
        .write_i      (1'b0),
        .fetch_i      (1'b1),
        .bases_i      (bases_flat),
        .attrs_i      (attrs_flat),
        .fault_o      (fetch_fault),
        .background_o (),
        .region_o     (),
        .attr_o       ()
    );

    // data stream
    access_check #(
        .NREG     (NREG),
        .REGION_W (REGION_W)
    ) u_data_check (
        .addr_valid_i (data_valid_i),
        .addr_i       (data_addr_i),
        .priv_i       (data_priv_i),
        .write_i      (data_write_i),
        .fetch_i      (1'b0),
        .bases_i      (bases_flat),
        .attrs_i      (attrs_flat),
        .fault_o      (data_fault),
        .background_o (data_bg),
        .region_o     (data_region),
        .attr_o       (data_attr)
    );

    // registered results; one cycle of latency keeps the decode off the
    // core's critical path at the cost of a late fault
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            fetch_fault_o           <= 1'b0;
            data_fault_o            <= 1'b0;
            mem_fault_o             <= 1'b0;
            data_background_o       <= 1'b0;
            data_strongly_ordered_o <= 1'b0;
            data_region_o           <= {REGION_W{1'b0}};
            data_mem_type_o         <= 6'h00;
        end else begin
            fetch_fault_o <= fetch_fault;
            data_fault_o  <= data_fault;
            mem_fault_o   <= fetch_fault | data_fault;
            if (data_valid_i) begin
                data_background_o <= data_bg;
                data_region_o     <= data_region;
                // background: default map applies, memory system decides
                data_mem_type_o   <= data_bg ? 6'h00 :
                                     data_attr[`ATTR_TEX_MSB:`ATTR_B_BIT];
                data_strongly_ordered_o <= !data_bg &&
                    (data_attr[`ATTR_TEX_MSB:`ATTR_TEX_LSB] == 3'h0) &&
                    !data_attr[`ATTR_C_BIT] &&
                    !data_attr[`ATTR_B_BIT];
            end else begin
                data_background_o       <= 1'b0;
                data_strongly_ordered_o <= 1'b0;
            end
        end
    end

endmodule // region_memory_protection_unit

/* File: bench/mpu_port_chk.sv */
// port assertions for the region memory protection unit
`timescale 1ns/1ps
module mpu_port_chk (
    // clock and reset
    input logic        clk_i,
    input logic        sys_rst_i,
    // register port
    input logic        reg_wr_i,
    input logic        reg_rd_i,
    input logic [31:0] reg_addr_i,
    input logic [1:0]  reg_size_i,
    input logic        reg_ack_o,
    input logic        reg_err_o,
    input logic [31:0] reg_rdata_o,
    // check ports
    input logic        fetch_valid_i,
    input logic        fetch_fault_o,
    input logic        data_valid_i,
    input logic        data_fault_o,
    input logic        data_background_o,
    input logic        data_strongly_ordered_o,
    input logic [5:0]  data_mem_type_o,
    input logic        mem_fault_o
);
    localparam logic [31:0] WIN_LO = 32'hE000ED98;
    localparam logic [31:0] WIN_HI = 32'hE000EDBC;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // one register request in flight
    sequence s_req;
        reg_wr_i || reg_rd_i;
    endsequence
    sequence s_answer;
        reg_ack_o;
    endsequence
    a_ack_follows_req: assert property (s_req |=> s_answer)
        else $error("request not answered next cycle");
    a_no_stray_ack: assert property (!(reg_wr_i || reg_rd_i) |=> !reg_ack_o)
        else $error("answer without request");
    a_err_with_ack: assert property (reg_err_o |-> reg_ack_o)
        else $error("error without answer");
    a_outside_refused: assert property ((reg_wr_i || reg_rd_i) &&
        (reg_addr_i < WIN_LO || reg_addr_i >= WIN_HI || reg_size_i == 2'h3)
        |=> reg_err_o)
        else $error("bad address or size accepted");
    a_select_word_only: assert property ((reg_wr_i || reg_rd_i)
        && reg_addr_i == WIN_LO && reg_size_i != 2'h2 |=> reg_err_o)
        else $error("narrow select access accepted");
    a_write_rdata_zero: assert property (reg_wr_i |=> reg_rdata_o == 32'h0)
        else $error("read data on a write answer");
    a_idle_fetch_quiet: assert property (!fetch_valid_i |=> !fetch_fault_o)
        else $error("fetch fault without fetch");
    a_idle_data_quiet: assert property (!data_valid_i |=> !data_fault_o)
        else $error("data fault without access");
    a_fault_combined: assert property (mem_fault_o == (fetch_fault_o
        || data_fault_o))
        else $error("combined fault disagrees");
    a_bg_type_zero: assert property (data_background_o |->
        data_mem_type_o == 6'h00 && !data_strongly_ordered_o)
        else $error("background reports a type");
    a_so_encoding: assert property (data_strongly_ordered_o |->
        data_mem_type_o[5:3] == 3'h0 && data_mem_type_o[1:0] == 2'h0)
        else $error("ordered flag with wrong type");
endmodule // mpu_port_chk
bind region_memory_protection_unit mpu_port_chk mpu_port_chk_inst (
    .clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_size_i,
    .reg_ack_o, .reg_err_o, .reg_rdata_o, .fetch_valid_i, .fetch_fault_o,
    .data_valid_i, .data_fault_o, .data_background_o,
    .data_strongly_ordered_o, .data_mem_type_o, .mem_fault_o);

/* File: bench/core_port_model.sv */
// model of the core issuing fetch and data accesses for checking
`timescale 1ns/1ps
module core_port_model (
    // clock
    input  logic        clk_i,
    // fetch request
    output logic        fetch_valid_o,
    output logic [31:0] fetch_addr_o,
    output logic        fetch_priv_o,
    // data request
    output logic        data_valid_o,
    output logic [31:0] data_addr_o,
    output logic        data_priv_o,
    output logic        data_write_o
);
    // idle at time zero
    initial begin
        fetch_valid_o = 1'b0;
        fetch_addr_o = 32'h0;
        fetch_priv_o = 1'b0;
        data_valid_o = 1'b0;
        data_addr_o = 32'h0;
        data_priv_o = 1'b0;
        data_write_o = 1'b0;
    end
    // one data access; idle lines flip so stale values cannot match
    task data_acc(input logic [31:0] a, input logic p, input logic w);
        @(posedge clk_i);
        data_valid_o <= 1'b1;
        data_addr_o <= a;
        data_priv_o <= p;
        data_write_o <= w;
        @(posedge clk_i);
        data_valid_o <= 1'b0;
        data_addr_o <= ~a;
        data_priv_o <= ~p;
        data_write_o <= ~w;
    endtask
    // one fetch, always a read
    task fetch_acc(input logic [31:0] a, input logic p);
        @(posedge clk_i);
        fetch_valid_o <= 1'b1;
        fetch_addr_o <= a;
        fetch_priv_o <= p;
        @(posedge clk_i);
        fetch_valid_o <= 1'b0;
        fetch_addr_o <= ~a;
        fetch_priv_o <= ~p;
    endtask
endmodule // core_port_model

/* File: bench/tb_region_memory_protection_unit.sv */
// self-checking bench for the region memory protection unit
`timescale 1ns/1ps
`include "region_memory_protection_unit_regs.vh"
module tb_region_memory_protection_unit;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic [31:0] reg_addr_i = 32'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [1:0]  reg_size_i = 2'h0;
    wire         reg_ack_o, reg_err_o, fetch_fault_o, data_fault_o;
    wire         data_background_o, data_strongly_ordered_o, mem_fault_o;
    wire         fetch_valid_i, fetch_priv_i, data_valid_i, data_priv_i;
    wire         data_write_i;
    wire [31:0]  reg_rdata_o, fetch_addr_i, data_addr_i;
    wire [2:0]   data_region_o;
    wire [5:0]   data_mem_type_o;
    int          fails = 0;
    int          tests_run = 0;
    localparam logic [1:0] W = `SIZE_WORD;
    always #20 clk_i = ~clk_i;
    region_memory_protection_unit region_memory_protection_unit_inst (
        .clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_size_i,
        .reg_wdata_i, .reg_ack_o, .reg_err_o, .reg_rdata_o, .fetch_valid_i,
        .fetch_addr_i, .fetch_priv_i, .fetch_fault_o, .data_valid_i,
        .data_addr_i, .data_priv_i, .data_write_i, .data_fault_o,
        .data_background_o, .data_strongly_ordered_o, .data_region_o,
        .data_mem_type_o, .mem_fault_o);
    core_port_model core_port_model_inst (.clk_i,
        .fetch_valid_o(fetch_valid_i), .fetch_addr_o(fetch_addr_i),
        .fetch_priv_o(fetch_priv_i), .data_valid_o(data_valid_i),
        .data_addr_o(data_addr_i), .data_priv_o(data_priv_i),
        .data_write_o(data_write_i));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one register access; answer is fixed at one cycle after taking
    task bus(input logic wr, input logic [7:0] off, input logic [1:0] sz,
             input logic [31:0] wd, input logic err, input logic [31:0] rd);
        @(posedge clk_i);
        reg_wr_i <= wr;
        reg_rd_i <= ~wr;
        reg_addr_i <= `REGION_SELECT_ADDR + {24'h0, off};
        reg_size_i <= sz;
        reg_wdata_i <= wd;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        reg_wdata_i <= ~wd;
        #1;
        chk(32'(reg_ack_o), 32'h1);
        chk(32'(reg_err_o), 32'(err));
        if (!wr) chk(reg_rdata_o, rd);
    endtask
    task dchk(input logic [31:0] a, input logic p, input logic w,
              input logic f, input logic bg, input logic [2:0] r);
        core_port_model_inst.data_acc(a, p, w);
        #1;
        chk(32'(data_fault_o), 32'(f));
        chk(32'(mem_fault_o), 32'(f));
        chk(32'(data_background_o), 32'(bg));
        if (!bg) chk(32'(data_region_o), 32'(r));
    endtask
    task fchk(input logic [31:0] a, input logic p, input logic f);
        core_port_model_inst.fetch_acc(a, p);
        #1;
        chk(32'(fetch_fault_o), 32'(f));
        chk(32'(mem_fault_o), 32'(f));
    endtask
    task results;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    initial begin
        #400000;
        fails++;
        results;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        bus(0, `OFF_REGION_SELECT, W, 0, 0, 32'h0);
        bus(0, `OFF_BASE, W, 0, 0, 32'h0);
        bus(0, `OFF_ATTR, W, 0, 0, 32'h0);
        dchk(32'h20000000, 0, 0, 1, 1, 0);
        dchk(32'h20000000, 1, 1, 0, 1, 0);
        $display("test reset done");
        // region 0 by separate words, full access, strongly ordered
        bus(1, `OFF_REGION_SELECT, W, 0, 0, 0);
        bus(1, `OFF_BASE, W, 32'h20000000, 0, 0);
        bus(1, `OFF_ATTR, W, 32'h03000013, 0, 0);
        dchk(32'h20000000, 0, 1, 0, 0, 3'h0);
        chk(32'(data_strongly_ordered_o), 32'h1);
        // region 3 by two words, read only, overlapping region 0
        bus(1, `OFF_BASE, W, 32'h20000013, 0, 0);
        bus(1, `OFF_ATTR, W, 32'h06020013, 0, 0);
        bus(0, `OFF_REGION_SELECT, W, 0, 0, 32'h3);
        dchk(32'h20000000, 0, 1, 1, 0, 3'h3);
        dchk(32'h20000000, 0, 0, 0, 0, 3'h3);
        chk(32'(data_mem_type_o), 32'h2);
        chk(32'(data_strongly_ordered_o), 32'h0);
        $display("test priority done");
        // disable first and last subregion of region 3 by a byte store
        bus(1, 8'h09, `SIZE_BYTE, 32'h00008100, 0, 0);
        bus(0, `OFF_ATTR, W, 0, 0, 32'h06028113);
        dchk(32'h20000000, 0, 1, 0, 0, 3'h0);
        dchk(32'h20000080, 0, 1, 1, 0, 3'h3);
        dchk(32'h200003F0, 0, 1, 0, 0, 3'h0);
        // region 0 off by halfword; disable before touching it
        bus(1, `OFF_REGION_SELECT, W, 0, 0, 0);
        bus(1, `OFF_ATTR, `SIZE_HALF, 32'h00000012, 0, 0);
        dchk(32'h20000000, 0, 0, 1, 1, 0);
        dchk(32'h20000000, 1, 0, 0, 1, 0);
        fchk(32'h20000080, 0, 0);
        fchk(32'h20000000, 0, 1);
        $display("test subregions done");
        // aliases program regions 5 and 7 over the same 32 bytes
        bus(1, `OFF_BASE_ALIAS1, W, 32'h30000015, 0, 0);
        bus(1, `OFF_ATTR_ALIAS1, W, 32'h03000009, 0, 0);
        bus(0, `OFF_BASE, W, 0, 0, 32'h30000005);
        dchk(32'h30000010, 0, 1, 0, 0, 3'h5);
        dchk(32'h30000020, 0, 0, 1, 1, 0);
        bus(1, `OFF_BASE_ALIAS3, W, 32'h30000017, 0, 0);
        bus(1, `OFF_ATTR_ALIAS3, W, 32'h01000009, 0, 0);
        dchk(32'h30000010, 0, 0, 1, 0, 3'h7);
        dchk(32'h30000010, 1, 1, 0, 0, 3'h7);
        $display("test aliases done");
        // refused accesses leave state alone
        bus(1, `OFF_REGION_SELECT, `SIZE_HALF, 32'h1, 1, 0);
        bus(0, 8'h24, W, 0, 1, 32'h0);
        bus(1, `OFF_ATTR, 2'h3, 32'h0, 1, 0);
        bus(1, 8'h09, `SIZE_HALF, 32'h0, 1, 0);
        bus(1, 8'h06, W, 32'h0, 1, 0);
        bus(0, `OFF_REGION_SELECT, W, 0, 0, 32'h7);
        // unwritable attribute bits read back zero; region stays off
        bus(1, `OFF_REGION_SELECT, W, 32'h6, 0, 0);
        bus(1, `OFF_ATTR, W, 32'hFFFFFFFE, 0, 0);
        bus(0, `OFF_ATTR, W, 0, 0, 32'h173FFF3E);
        $display("test refusals done");
        results;
    end
endmodule // tb_region_memory_protection_unit
